//--- core/sdam_ctrl.sv
// Operation
// R1: Row strobe is low only while the row address stands on the pins.
// R2: Column strobe is low only while the column address stands on the pins.
// R3: Write_not_read is high for writes and low for reads.
// R4: Two block selects, each driving the chip select of one SDRAM block.
// R5: Board never wires block selects to the SDRAM row strobe input.
// R6: Clock enable output driven by the block; low allows power-down or self-refresh.
// R7: A control bit makes the clock enable pin carry a command bit.
// R8: Four byte lane masks act as per-byte enables to SDRAM data masks.
// R9: Bus clock output clocks every SDRAM; all SDRAM signals synchronous to it.
// R10: In the row phase, pins 9 to 25 carry address bits of equal number.
// R11: For 8-bit ports, pins 17 down to 9 carry column bits 0 to 8.
// R12: Pin 16 carries column bit 1 for 8/16-bit ports; pins 15..9 bits 2..8.
// R13: Pin 18 carries bit 17 for 16-bit, or 32-bit with eight column lines.
// R14: For 16-bit ports pin 19 carries bit 18 with nine or more column lines.
// R15: Pins 20 to 25 carry column bits 19 to 24; code keeps row bits there for 8-bit ports with up to 10 column lines.
// R16: 8-bit, 10 columns: pin 19 carries bit 18; pins 20 upward row only.
// R17: Mapping is chosen by the port width seen, not per-device width.
// R18: Board wires SDRAM address inputs in order from address 0.
// R19: Row address with row strobe first, column address with column strobe later.
`timescale 1ns/1ps
module sdam_ctrl
  import sdam_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // Configuration
  input  wire logic [1:0]             port_size,
  input  wire logic [3:0]             col_lines,
  input  wire logic                   command_on_clock_enable,
  input  wire logic                   clock_enable_command,
  input  wire logic                   power_down_req,
  input  wire logic                   bus_clock_stop,
  // Access request
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic                   req_block,
  input  wire logic [SDAM_ADDR_W-1:0] req_addr,
  input  wire logic [3:0]             req_byte_en,
  output logic                        req_ready,
  output logic                        req_done,
  // SDRAM pins
  output logic [SDAM_PIN_W-1:0]       addr_pins,
  output logic                        row_strobe_n,
  output logic                        column_strobe_n,
  output logic                        write_not_read,
  output logic [1:0]                  sdram_block_select_n,
  output logic                        sdram_clock_enable,
  output logic [3:0]                  byte_lane_mask,
  output logic                        bus_clock_out_enable
);

  sdam_state_t            state_q;
  logic [3:0]             wait_q;
  logic [SDAM_ADDR_W-1:0] addr_q;
  logic                   write_q;
  logic                   block_q;
  logic [3:0]             be_q;
  logic [1:0]             port_q;
  logic [3:0]             cols_q;
  logic                   ready_q;
  logic                   done_q;
  logic [SDAM_PIN_W-1:0]  pins_q;
  logic                   ras_n_q;
  logic                   cas_n_q;
  logic                   wnr_q;
  logic [1:0]             sel_n_q;
  logic                   cke_q;
  logic [3:0]             mask_q;
  logic                   clk_en_q;
  logic                   take;

  sdam_mux_if mux_bus ();

  assign take              = (state_q == SDAM_IDLE) && req_valid && ready_q;
  assign mux_bus.addr      = addr_q;
  assign mux_bus.port_size = port_q;
  assign mux_bus.col_lines = cols_q;
  assign mux_bus.col_phase = (state_q == SDAM_COL);

  sdam_addr_mux u_mux (
    .m (mux_bus.mux)
  );

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q <= SDAM_IDLE;
      wait_q  <= 4'h0;
    end
    else
    begin
      case (state_q)
        SDAM_IDLE:
        begin
          if (take)
          begin
            state_q <= SDAM_ROW;
          end
        end
        SDAM_ROW:
        begin
          state_q <= SDAM_WAIT;
          wait_q  <= SDAM_RCD_CNT;
        end
        SDAM_WAIT:
        begin
          if (wait_q <= 4'h1)
          begin
            state_q <= SDAM_COL; // R19
          end
          wait_q <= wait_q - 4'h1;
        end
        SDAM_COL:
        begin
          state_q <= SDAM_IDLE;
        end
        default:
        begin
          state_q <= SDAM_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request capture and handshake
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      addr_q  <= 32'h00000000;
      write_q <= 1'b0;
      block_q <= 1'b0;
      be_q    <= 4'h0;
      port_q  <= SDAM_PORT_32;
      cols_q  <= SDAM_COLS_8;
    end
    else if (take)
    begin
      addr_q  <= req_addr;
      write_q <= req_write;
      block_q <= req_block;
      be_q    <= req_byte_en;
      port_q  <= port_size; // R17
      cols_q  <= col_lines;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ready_q <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      ready_q <= (state_q == SDAM_IDLE && !take) || (state_q == SDAM_COL);
      done_q  <= (state_q == SDAM_COL);
    end
  end

  // ----------------------------------------------------------------
  // SDRAM address and command pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pins_q  <= SDAM_PINS_RST;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      wnr_q   <= 1'b0;
      sel_n_q <= SDAM_SEL_IDLE;
      mask_q  <= SDAM_MASK_IDLE;
    end
    else
    begin
      ras_n_q <= !(state_q == SDAM_ROW); // R1
      cas_n_q <= !(state_q == SDAM_COL); // R2
      mask_q  <= (state_q == SDAM_COL) ? ~be_q : SDAM_MASK_IDLE; // R8
      if (state_q == SDAM_ROW || state_q == SDAM_COL)
      begin
        pins_q  <= mux_bus.pins; // R19
        wnr_q   <= write_q; // R3
        sel_n_q <= block_q ? 2'h1 : 2'h2; // R4
      end
      else
      begin
        sel_n_q <= SDAM_SEL_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock enable and bus clock gating
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cke_q    <= 1'b1;
      clk_en_q <= 1'b1;
    end
    else
    begin
      cke_q    <= command_on_clock_enable ? clock_enable_command : !power_down_req; // R6 R7
      clk_en_q <= !bus_clock_stop; // R9
    end
  end

  assign req_ready            = ready_q;
  assign req_done             = done_q;
  assign addr_pins            = pins_q;
  assign row_strobe_n         = ras_n_q;
  assign column_strobe_n      = cas_n_q;
  assign write_not_read       = wnr_q;
  assign sdram_block_select_n = sel_n_q;
  assign sdram_clock_enable   = cke_q;
  assign byte_lane_mask       = mask_q;
  assign bus_clock_out_enable = clk_en_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_row_addr_pins: assert property (!row_strobe_n |-> addr_pins == addr_q[25:9]) // R1 R10
    else $error("row strobe without row address on pins");
  chk_col_after_row: assert property ($fell(row_strobe_n) |-> ##[1:4] !column_strobe_n) // R19
    else $error("column strobe did not follow row strobe");
  chk_col_one_cycle: assert property (!column_strobe_n |=> column_strobe_n && row_strobe_n) // R2
    else $error("column strobe held too long");
  chk_col_low_bits: assert property (!column_strobe_n |-> addr_pins[6:0] == {addr_q[2], addr_q[3], // R12
    addr_q[4], addr_q[5], addr_q[6], addr_q[7], addr_q[8]})
    else $error("pins 15 to 9 wrong in column phase");
  chk_col_8bit: assert property (!column_strobe_n && port_q == SDAM_PORT_8 |-> addr_pins[8] == addr_q[0]) // R11
    else $error("pin 17 wrong for 8-bit port");
  chk_col_high: assert property (!column_strobe_n && port_q == SDAM_PORT_16 // R15
    |-> addr_pins[16:11] == addr_q[24:19])
    else $error("pins 20 to 25 wrong in column phase");
  chk_col_pin18: assert property (!column_strobe_n && port_q == SDAM_PORT_16 |-> addr_pins[9] == addr_q[17]) // R13
    else $error("pin 18 wrong for 16-bit port");
  chk_col_pin19: assert property (!column_strobe_n && port_q == SDAM_PORT_8 && cols_q == SDAM_COLS_10 // R16
    |-> addr_pins[10] == addr_q[18] && addr_pins[11] == addr_q[20])
    else $error("pins 19 and 20 wrong for 8-bit port");
  chk_write_level: assert property (!column_strobe_n |-> write_not_read == write_q) // R3
    else $error("write level wrong at column strobe");
  chk_one_block: assert property (!row_strobe_n || !column_strobe_n |-> $onehot(~sdram_block_select_n)) // R4
    else $error("block select not one-hot during access");
  chk_mask_lanes: assert property (column_strobe_n |-> byte_lane_mask == SDAM_MASK_IDLE) // R8
    else $error("byte lanes enabled outside column phase");
  chk_cke_source: assert property (sdram_clock_enable == ($past(command_on_clock_enable) ? // R6 R7
    $past(clock_enable_command) : !$past(power_down_req)))
    else $error("clock enable source wrong");

endmodule

//--- core/sdam_pkg.sv
package sdam_pkg;

  // ----------------------------------------------------------------
  // Port size and column line encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SDAM_PORT_32  = 2'h0;
  localparam logic [1:0] SDAM_PORT_16  = 2'h1;
  localparam logic [1:0] SDAM_PORT_8   = 2'h2;
  localparam logic [3:0] SDAM_COLS_8   = 4'h8;
  localparam logic [3:0] SDAM_COLS_9   = 4'h9;
  localparam logic [3:0] SDAM_COLS_10  = 4'ha;

  // ----------------------------------------------------------------
  // Pin range and field positions
  // ----------------------------------------------------------------
  localparam int SDAM_PIN_LO  = 9;
  localparam int SDAM_PIN_HI  = 25;
  localparam int SDAM_PIN_W   = SDAM_PIN_HI - SDAM_PIN_LO + 1;
  localparam int SDAM_ADDR_W  = 32;

  // ----------------------------------------------------------------
  // Reset and idle values
  // ----------------------------------------------------------------
  localparam logic [3:0]            SDAM_MASK_IDLE = 4'hf;
  localparam logic [1:0]            SDAM_SEL_IDLE  = 2'h3;
  localparam logic [SDAM_PIN_W-1:0] SDAM_PINS_RST  = 17'h00000;

  // ----------------------------------------------------------------
  // Timing: row strobe to column strobe
  // ----------------------------------------------------------------
  localparam int SDAM_CLK_NS    = 50;
  localparam int SDAM_RCD_NS    = 20;
  localparam int SDAM_RCD_RAW   = (SDAM_RCD_NS + SDAM_CLK_NS - 1) / SDAM_CLK_NS;
  localparam int SDAM_RCD_CYC   = (SDAM_RCD_RAW < 1) ? 1 : SDAM_RCD_RAW;
  localparam logic [3:0] SDAM_RCD_CNT = 4'(SDAM_RCD_CYC);

  // ----------------------------------------------------------------
  // Access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SDAM_IDLE, SDAM_ROW, SDAM_WAIT, SDAM_COL} sdam_state_t;

endpackage

//--- core/sdam_mux_if.sv
`timescale 1ns/1ps
interface sdam_mux_if;
  import sdam_pkg::*;

  logic [SDAM_ADDR_W-1:0] addr;
  logic [1:0]             port_size;
  logic [3:0]             col_lines;
  logic                   col_phase;
  logic [SDAM_PIN_W-1:0]  pins;

  modport ctrl (output addr, output port_size, output col_lines, output col_phase, input pins);
  modport mux  (input addr, input port_size, input col_lines, input col_phase, output pins);
endinterface

//--- core/sdam_addr_mux.sv
`timescale 1ns/1ps
module sdam_addr_mux
  import sdam_pkg::*;
(
  // Address and configuration in, pin values out
  sdam_mux_if.mux m
);

  logic is8;
  logic is16;
  logic is32;
  logic [SDAM_PIN_W-1:0] pin;

  assign is8  = (m.port_size == SDAM_PORT_8);
  assign is16 = (m.port_size == SDAM_PORT_16);
  assign is32 = (m.port_size == SDAM_PORT_32);

  // ----------------------------------------------------------------
  // Row or column address onto pins 9 to 25
  // ----------------------------------------------------------------
  always_comb
  begin
    pin = m.addr[SDAM_PIN_HI:SDAM_PIN_LO]; // R10
    if (m.col_phase)
    begin
      for (int p = 9; p <= 15; p++)
      begin
        pin[p-SDAM_PIN_LO] = m.addr[17-p]; // R12
      end
      if (is8)
      begin
        pin[17-SDAM_PIN_LO] = m.addr[0]; // R11
      end
      else if (is32)
      begin
        pin[17-SDAM_PIN_LO] = m.addr[16];
      end
      if (is8 || is16)
      begin
        pin[16-SDAM_PIN_LO] = m.addr[1]; // R12
      end
      if (is16 || (is32 && m.col_lines == SDAM_COLS_8))
      begin
        pin[18-SDAM_PIN_LO] = m.addr[17]; // R13
      end
      if ((is16 && m.col_lines >= SDAM_COLS_9) || (is8 && m.col_lines >= SDAM_COLS_10))
      begin
        pin[19-SDAM_PIN_LO] = m.addr[18]; // R14 R16
      end
      if (!(is8 && m.col_lines <= SDAM_COLS_10))
      begin
        for (int p = 20; p <= 25; p++)
        begin
          pin[p-SDAM_PIN_LO] = m.addr[p-1]; // R15
        end
      end
    end
  end

  assign m.pins = pin;

endmodule

//--- sim/sdam_sdram_model.sv
`timescale 1ns/1ps
module sdam_sdram_model
  import sdam_pkg::*;
(
  // Bus clock and SDRAM pins
  input  wire logic                  bus_clk,
  input  wire logic [SDAM_PIN_W-1:0] addr_pins,
  input  wire logic                  row_strobe_n,
  input  wire logic                  column_strobe_n,
  input  wire logic                  write_not_read,
  input  wire logic [1:0]            sdram_block_select_n,
  input  wire logic                  sdram_clock_enable,
  input  wire logic [3:0]            byte_lane_mask,
  // Latched command fields
  output logic [SDAM_PIN_W-1:0]      row_q,
  output logic [SDAM_PIN_W-1:0]      col_q,
  output logic [1:0]                 blk_q,
  output logic                       wr_q,
  output logic [3:0]                 mask_q,
  output logic [3:0]                 gap_q
);
  logic [3:0] since_row = 4'h0;

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  // Every field is sampled on the bus clock edge, as a real device does.
  always @(posedge bus_clk)
  begin
    since_row <= since_row + 4'h1;
    if (sdram_clock_enable && sdram_block_select_n != 2'h3)
    begin
      if (!row_strobe_n)
      begin
        row_q     <= addr_pins;
        since_row <= 4'h0;
      end
      if (!column_strobe_n)
      begin
        col_q  <= addr_pins;
        blk_q  <= sdram_block_select_n;
        wr_q   <= write_not_read;
        mask_q <= byte_lane_mask;
        gap_q  <= since_row + 4'h1;
      end
    end
  end
endmodule

//--- sim/sdram_address_mux_tb.sv
`timescale 1ns/1ps
module sdram_address_mux_tb
  import sdam_pkg::*;
;
  logic                  sys_clk;
  logic                  reset;
  logic [1:0]            port_size;
  logic [3:0]            col_lines;
  logic                  command_on_clock_enable;
  logic                  clock_enable_command;
  logic                  power_down_req;
  logic                  bus_clock_stop;
  logic                  req_valid;
  logic                  req_write;
  logic                  req_block;
  logic [31:0]           req_addr;
  logic [3:0]            req_byte_en;
  logic                  req_ready;
  logic                  req_done;
  logic [SDAM_PIN_W-1:0] addr_pins;
  logic                  row_strobe_n;
  logic                  column_strobe_n;
  logic                  write_not_read;
  logic [1:0]            sdram_block_select_n;
  logic                  sdram_clock_enable;
  logic [3:0]            byte_lane_mask;
  logic                  bus_clock_out_enable;
  logic [SDAM_PIN_W-1:0] row_q;
  logic [SDAM_PIN_W-1:0] col_q;
  logic [1:0]            blk_q;
  logic                  wr_q;
  logic [3:0]            mask_q;
  logic [3:0]            gap_q;
  int                    bad_count = 0;
  int                    n_checks = 0;
  int                    cycles = 0;

  localparam logic [1:0] PS_TAB [6] = '{SDAM_PORT_8, SDAM_PORT_8, SDAM_PORT_16, SDAM_PORT_16,
                                        SDAM_PORT_32, SDAM_PORT_32};
  localparam logic [3:0] CL_TAB [6] = '{SDAM_COLS_9, SDAM_COLS_10, SDAM_COLS_8, SDAM_COLS_9, SDAM_COLS_8, SDAM_COLS_9};

  sdam_ctrl dut (.sys_clk(sys_clk), .reset(reset), .port_size(port_size), .col_lines(col_lines),
    .command_on_clock_enable(command_on_clock_enable), .clock_enable_command(clock_enable_command),
    .power_down_req(power_down_req), .bus_clock_stop(bus_clock_stop), .req_valid(req_valid),
    .req_write(req_write), .req_block(req_block), .req_addr(req_addr), .req_byte_en(req_byte_en),
    .req_ready(req_ready), .req_done(req_done), .addr_pins(addr_pins), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_not_read(write_not_read),
    .sdram_block_select_n(sdram_block_select_n), .sdram_clock_enable(sdram_clock_enable),
    .byte_lane_mask(byte_lane_mask), .bus_clock_out_enable(bus_clock_out_enable));

  sdam_sdram_model mem (.bus_clk(sys_clk), .addr_pins(addr_pins), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_not_read(write_not_read),
    .sdram_block_select_n(sdram_block_select_n), .sdram_clock_enable(sdram_clock_enable),
    .byte_lane_mask(byte_lane_mask), .row_q(row_q), .col_q(col_q), .blk_q(blk_q), .wr_q(wr_q),
    .mask_q(mask_q), .gap_q(gap_q));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [16:0] col_exp(input logic [31:0] a, input logic [1:0] ps, input logic [3:0] cl);
    logic [16:0] e;
    e = a[25:9];
    for (int p = 9; p <= 15; p++) e[p-9] = a[17-p];
    if (ps == SDAM_PORT_8 || ps == SDAM_PORT_16) e[7] = a[1];
    if (ps == SDAM_PORT_8) e[8] = a[0];
    if (ps == SDAM_PORT_32) e[8] = a[16];
    if (ps == SDAM_PORT_16 || (ps == SDAM_PORT_32 && cl == SDAM_COLS_8)) e[9] = a[17];
    if ((ps == SDAM_PORT_16 && cl >= SDAM_COLS_9) || (ps == SDAM_PORT_8 && cl == SDAM_COLS_10)) e[10] = a[18];
    if (ps != SDAM_PORT_8) for (int p = 20; p <= 25; p++) e[p-9] = a[p-1];
    return e;
  endfunction

  task automatic do_access(input logic [31:0] a, input logic wr, input logic blk, input logic [3:0] be,
                           input logic [1:0] ps, input logic [3:0] cl);
    int n;
    port_size   = ps;
    col_lines   = cl;
    req_addr    = a;
    req_write   = wr;
    req_block   = blk;
    req_byte_en = be;
    req_valid   = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 1;
    while (req_done !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(n, 4, "take to column");
    @(negedge sys_clk);
    check(row_q, a[25:9], "row address");
    check(col_q, col_exp(a, ps, cl), "column address");
    check(wr_q, wr, "write flag");
    check(blk_q, blk ? 2'h1 : 2'h2, "block select");
    check(mask_q, 4'(~be), "byte mask");
    check(gap_q, 2, "row to column gap");
    check(byte_lane_mask, SDAM_MASK_IDLE, "idle mask");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scen_idle();
    check({row_strobe_n, column_strobe_n}, 2'h3, "idle strobes");
    check(sdram_block_select_n, SDAM_SEL_IDLE, "idle selects");
    check(sdram_clock_enable, 1'b1, "idle clock enable");
    check({req_ready, req_done}, 2'h2, "handshake after reset");
  endtask

  task automatic scen_mapping();
    for (int i = 0; i < 6; i++)
      do_access(32'h02b4_d369 ^ (32'h0135_79bd << i), i[0], i[1], 4'(i * 3 + 1), PS_TAB[i], CL_TAB[i]);
  endtask

  task automatic scen_clock_enable();
    power_down_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(sdram_clock_enable, 1'b0, "power down");
    command_on_clock_enable = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(sdram_clock_enable, 1'b0, "command bit low");
    clock_enable_command = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(sdram_clock_enable, 1'b1, "command bit high");
    command_on_clock_enable = 1'b0;
    power_down_req = 1'b0;
    bus_clock_stop = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({sdram_clock_enable, bus_clock_out_enable}, 2'h2, "bus clock stopped");
    bus_clock_stop = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(bus_clock_out_enable, 1'b1, "bus clock running");
  endtask

  initial
  begin
    reset = 1'b1;
    port_size = SDAM_PORT_32;
    col_lines = SDAM_COLS_8;
    command_on_clock_enable = 1'b0;
    clock_enable_command = 1'b0;
    power_down_req = 1'b0;
    bus_clock_stop = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_block = 1'b0;
    req_addr = 32'h0;
    req_byte_en = 4'h0;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    scen_idle();
    scen_mapping();
    scen_clock_enable();
    give_verdict();
  end
endmodule
